// ===== design/dtw_defines.svh
`ifndef DTW_DEFINES_SVH
`define DTW_DEFINES_SVH

// Core clock and tick rates, in Hz
`define DTW_CLK_HZ 100000000
`define DTW_GP_TICK_HZ 812500
`define DTW_WD_TICK_HZ 928000

// Accumulator width of the fractional tick dividers
`define DTW_ACC_W 27

// Widths and number of timers
`define DTW_GP_WIDTH 16
`define DTW_NUM_TIMERS 2
`define DTW_WD_WIDTH 16
`define DTW_WD_PRE_W 7
`define DTW_WD_PS_W 3

// Reset values
`define DTW_CNT_RST 16'h0000
`define DTW_PRE_RST 7'h00

`endif

// ===== design/dtw_pkg.sv
`default_nettype none
package dtw_pkg;

  typedef logic [15:0] dtw_cnt_t;
  typedef logic [2:0] dtw_ps_t;

  typedef enum logic {
    DTW_TMR_IDLE = 1'b0,
    DTW_TMR_RUN = 1'b1
  } dtw_tmr_state_e;

  typedef enum logic [1:0] {
    DTW_WD_OFF = 2'b00,
    DTW_WD_RUN = 2'b01,
    DTW_WD_BITE = 2'b11
  } dtw_wd_state_e;

endpackage
`default_nettype wire

// ===== design/dtw_gp_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "dtw_defines.svh"

module dtw_gp_timer #(
  parameter int WIDTH = `DTW_GP_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_auto_reload,
  input wire logic [WIDTH-1:0] i_load,
  output logic [WIDTH-1:0] o_count,
  output logic o_running,
  output logic o_irq
);
  import dtw_pkg::*;

  dtw_tmr_state_e state, next_state;
  logic [WIDTH-1:0] reload, next_reload;
  logic [WIDTH-1:0] next_count;
  logic auto_mode, next_auto_mode;
  logic next_irq;
  logic next_running;

  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_reload = reload;
    next_count = o_count;
    next_auto_mode = auto_mode;
    next_irq = 1'b0;
    case (state)
      DTW_TMR_IDLE: begin
        if (i_start) begin
          next_state = DTW_TMR_RUN;
          next_count = i_load;
          next_reload = i_load;
          next_auto_mode = i_auto_reload;
        end
      end
      DTW_TMR_RUN: begin
        if (i_stop) begin
          next_state = DTW_TMR_IDLE;
        end else if (i_start) begin
          next_count = i_load;
          next_reload = i_load;
          next_auto_mode = i_auto_reload;
        end else if (i_tick) begin
          if (o_count == '0) begin
            next_irq = 1'b1;
            if (auto_mode) begin
              next_count = reload;
            end else begin
              next_state = DTW_TMR_IDLE;
            end
          end else begin
            next_count = o_count - 1'b1;
          end
        end
      end
      default: begin
        next_state = DTW_TMR_IDLE;
      end
    endcase
    // Running flag registered so the output comes from a flop
    next_running = (next_state == DTW_TMR_RUN);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= DTW_TMR_IDLE;
      reload <= '0;
      o_count <= '0;
      auto_mode <= 1'b0;
      o_irq <= 1'b0;
      o_running <= 1'b0;
    end else begin
      state <= next_state;
      reload <= next_reload;
      o_count <= next_count;
      auto_mode <= next_auto_mode;
      o_irq <= next_irq;
      o_running <= next_running;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_expire;
    o_running && i_tick && !i_stop && !i_start && (o_count == '0);
  endsequence

  property p_irq_on_expiry;
    s_expire |=> o_irq ##1 !o_irq;
  endproperty
  a_irq_on_expiry: assert property (p_irq_on_expiry) else $error("no irq on expiry");

  property p_oneshot_stops;
    (s_expire and !auto_mode) |=> !o_running;
  endproperty
  a_oneshot_stops: assert property (p_oneshot_stops) else $error("one-shot kept running");

  property p_auto_reloads;
    (s_expire and auto_mode) |=> o_running && (o_count == $past(reload));
  endproperty
  a_auto_reloads: assert property (p_auto_reloads) else $error("auto-reload failed");

  property p_decrement;
    (o_running && i_tick && !i_stop && !i_start && (o_count != '0))
      |=> (o_count == $past(o_count) - 1'b1);
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement");

  property p_hold_between_ticks;
    (o_running && !i_tick && !i_stop && !i_start) |=> $stable(o_count) && !o_irq;
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("count moved");

endmodule
`default_nettype wire

// ===== design/dtw_timer_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "dtw_defines.svh"


module dtw_timer_unit #(
  parameter int NUM_TIMERS = `DTW_NUM_TIMERS,
  parameter int GP_WIDTH = `DTW_GP_WIDTH
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic [NUM_TIMERS-1:0] I_TMR_START,
  input wire logic [NUM_TIMERS-1:0] I_TMR_STOP,
  input wire logic [NUM_TIMERS-1:0] I_TMR_AUTO_RELOAD,
  input wire logic [NUM_TIMERS-1:0][GP_WIDTH-1:0] I_TMR_LOAD,
  input wire logic I_WDOG_EN,
  input wire logic I_WDOG_KICK,
  input wire dtw_pkg::dtw_cnt_t I_WDOG_LOAD,
  input wire dtw_pkg::dtw_ps_t I_WDOG_PRESCALE,
  output logic [NUM_TIMERS-1:0][GP_WIDTH-1:0] O_TMR_COUNT,
  output logic [NUM_TIMERS-1:0] O_TMR_RUNNING,
  output logic [NUM_TIMERS-1:0] O_TMR_IRQ,
  output dtw_pkg::dtw_cnt_t O_WDOG_COUNT,
  output logic O_WDOG_EXPIRED
);
  import dtw_pkg::*;

  localparam logic [`DTW_ACC_W-1:0] CLK_HZ = `DTW_ACC_W'(`DTW_CLK_HZ);

  logic rst_meta, rst_n;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Fractional tick dividers (0: timers, 1: watchdog)
  // ----------------------------------------
  logic [1:0] tick;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tick
      localparam logic [`DTW_ACC_W-1:0] STEP =
        (g == 0) ? `DTW_ACC_W'(`DTW_GP_TICK_HZ) : `DTW_ACC_W'(`DTW_WD_TICK_HZ);
      logic [`DTW_ACC_W-1:0] acc, next_acc;
      logic next_tick;
      // Average rate exactly STEP per second, jitter one core cycle
      always_comb begin
        next_acc = acc + STEP;
        next_tick = 1'b0;
        if (next_acc >= CLK_HZ) begin
          next_acc = next_acc - CLK_HZ;
          next_tick = 1'b1;
        end
      end
      always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
          acc <= '0;
          tick[g] <= 1'b0;
        end else begin
          acc <= next_acc;
          tick[g] <= next_tick;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // General-purpose timers
  // ----------------------------------------
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      dtw_gp_timer #(
        .WIDTH(GP_WIDTH)
      ) u_tmr (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n),
        .i_tick(tick[0]),
        .i_start(I_TMR_START[g]),
        .i_stop(I_TMR_STOP[g]),
        .i_auto_reload(I_TMR_AUTO_RELOAD[g]),
        .i_load(I_TMR_LOAD[g]),
        .o_count(O_TMR_COUNT[g]),
        .o_running(O_TMR_RUNNING[g]),
        .o_irq(O_TMR_IRQ[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  dtw_wd_state_e wd_state, next_wd_state;
  logic [`DTW_WD_PRE_W-1:0] wd_pre, next_wd_pre;
  logic [`DTW_WD_PRE_W-1:0] pre_mask;
  dtw_cnt_t next_wd_count;
  logic next_wd_expired;
  logic wd_step;

  // Step every 2**prescale watchdog ticks
  assign pre_mask = `DTW_WD_PRE_W'((8'h01 << I_WDOG_PRESCALE) - 8'h01);
  assign wd_step = tick[1] && ((wd_pre & pre_mask) == pre_mask);

  always_comb begin
    next_wd_state = wd_state;
    next_wd_pre = wd_pre;
    next_wd_count = O_WDOG_COUNT;
    next_wd_expired = O_WDOG_EXPIRED;
    case (wd_state)
      DTW_WD_OFF: begin
        next_wd_expired = 1'b0;
        if (I_WDOG_EN) begin
          next_wd_state = DTW_WD_RUN;
          next_wd_count = I_WDOG_LOAD;
          next_wd_pre = `DTW_PRE_RST;
        end
      end
      DTW_WD_RUN: begin
        if (!I_WDOG_EN) begin
          next_wd_state = DTW_WD_OFF;
        end else if (I_WDOG_KICK) begin
          next_wd_count = I_WDOG_LOAD;
          next_wd_pre = `DTW_PRE_RST;
        end else if (tick[1]) begin
          next_wd_pre = wd_step ? `DTW_PRE_RST : wd_pre + 1'b1;
          if (wd_step) begin
            if (O_WDOG_COUNT == `DTW_CNT_RST) begin
              next_wd_state = DTW_WD_BITE;
              next_wd_expired = 1'b1;
            end else begin
              next_wd_count = O_WDOG_COUNT - 1'b1;
            end
          end
        end
      end
      DTW_WD_BITE: begin
        // Held until software disables the watchdog
        if (!I_WDOG_EN) begin
          next_wd_state = DTW_WD_OFF;
          next_wd_expired = 1'b0;
        end
      end
      default: begin
        next_wd_state = DTW_WD_OFF;
        next_wd_expired = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_state <= DTW_WD_OFF;
      wd_pre <= `DTW_PRE_RST;
      O_WDOG_COUNT <= `DTW_CNT_RST;
      O_WDOG_EXPIRED <= 1'b0;
    end else begin
      wd_state <= next_wd_state;
      wd_pre <= next_wd_pre;
      O_WDOG_COUNT <= next_wd_count;
      O_WDOG_EXPIRED <= next_wd_expired;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!rst_n);

  property p_gp_tick_sparse;
    tick[0] |=> !tick[0] [*8];
  endproperty
  a_gp_tick_sparse: assert property (p_gp_tick_sparse) else $error("timer tick too fast");

  property p_gp_tick_period;
    tick[0] |-> ##[123:124] tick[0];
  endproperty
  a_gp_tick_period: assert property (p_gp_tick_period) else $error("timer tick late");

  property p_wd_tick_period;
    tick[1] |-> ##[107:108] tick[1];
  endproperty
  a_wd_tick_period: assert property (p_wd_tick_period) else $error("watchdog tick late");

  property p_wd_bite;
    (wd_state == DTW_WD_RUN && I_WDOG_EN && !I_WDOG_KICK && wd_step &&
      O_WDOG_COUNT == `DTW_CNT_RST) |=> O_WDOG_EXPIRED;
  endproperty
  a_wd_bite: assert property (p_wd_bite) else $error("watchdog failed to expire");

  property p_wd_kick;
    (wd_state == DTW_WD_RUN && I_WDOG_EN && I_WDOG_KICK)
      |=> (O_WDOG_COUNT == $past(I_WDOG_LOAD)) && (wd_pre == `DTW_PRE_RST) && !O_WDOG_EXPIRED;
  endproperty
  a_wd_kick: assert property (p_wd_kick) else $error("kick did not reload");

  property p_wd_hold_without_step;
    (wd_state == DTW_WD_RUN && I_WDOG_EN && !I_WDOG_KICK && !wd_step) |=> $stable(O_WDOG_COUNT);
  endproperty
  a_wd_hold_without_step: assert property (p_wd_hold_without_step) else $error("wd moved");

  // No tick in the stop cycle, so the other timer cannot expire then
  property p_timers_independent;
    (I_TMR_STOP[0] && O_TMR_RUNNING[0] && O_TMR_RUNNING[1] && !I_TMR_STOP[1] && !tick[0])
      |=> !O_TMR_RUNNING[0] && O_TMR_RUNNING[1];
  endproperty
  a_timers_independent: assert property (p_timers_independent) else $error("timers coupled");

  property p_timers_independent_1;
    (I_TMR_STOP[1] && O_TMR_RUNNING[1] && O_TMR_RUNNING[0] && !I_TMR_STOP[0] && !tick[0])
      |=> !O_TMR_RUNNING[1] && O_TMR_RUNNING[0];
  endproperty
  a_timers_independent_1: assert property (p_timers_independent_1) else $error("timers coupled");

endmodule
`default_nettype wire

// ===== verif/tb_dtw_timer_unit.sv
`timescale 1ns/1ns
`default_nettype none
module tb_dtw_timer_unit;
  import dtw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] start = 2'h0;
  logic [1:0] stop = 2'h0;
  logic [1:0] auto = 2'h0;
  logic [1:0][15:0] load = '0;
  logic wd_en = 1'b0;
  logic kick = 1'b0;
  dtw_cnt_t wd_load = 16'h0000;
  dtw_ps_t wd_ps = 3'h0;
  logic [1:0][15:0] count;
  logic [1:0] running;
  logic [1:0] irq;
  dtw_cnt_t wd_count;
  logic wd_expired;
  int failures = 0;
  int n_compared = 0;
  int n;

  dtw_timer_unit i_dtw_timer_unit (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_TMR_START(start), .I_TMR_STOP(stop),
    .I_TMR_AUTO_RELOAD(auto), .I_TMR_LOAD(load), .I_WDOG_EN(wd_en),
    .I_WDOG_KICK(kick), .I_WDOG_LOAD(wd_load), .I_WDOG_PRESCALE(wd_ps),
    .O_TMR_COUNT(count), .O_TMR_RUNNING(running), .O_TMR_IRQ(irq),
    .O_WDOG_COUNT(wd_count), .O_WDOG_EXPIRED(wd_expired)
  );

  always #5 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pulse_start(input int i, input logic [15:0] ld, input logic ar);
    load[i] = ld;
    auto[i] = ar;
    start[i] = 1'b1;
    step(1);
    start[i] = 1'b0;
  endtask

  // Source 0/1 is a timer interrupt, 2 the watchdog expiry
  task automatic wait_on(input int sel, input int max, output int k);
    k = 0;
    do begin
      step(1);
      k++;
    end while (((sel == 2) ? wd_expired : irq[sel]) !== 1'b1 && k < max);
  endtask

  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_one_shot();
    pulse_start(0, 16'h0002, 1'b0);
    check("os running", running[0], 1'b1);
    check("os count", count[0], 16'h0002);
    wait_on(0, 500, n);
    check("os period", n >= 246 && n <= 374, 1'b1);
    check("os stop", running[0], 1'b0);
    check("os irq", irq[0], 1'b1);
    wait_on(0, 600, n);
    check("os no second irq", n, 600);
  endtask

  task automatic t_auto_and_independence();
    pulse_start(0, 16'h0005, 1'b0);
    pulse_start(1, 16'h0001, 1'b1);
    wait_on(1, 400, n);
    check("ar first irq", irq[1], 1'b1);
    check("ar reload", count[1], 16'h0001);
    check("ar running", running[1], 1'b1);
    check("other quiet", irq[0], 1'b0);
    check("other running", running[0], 1'b1);
    wait_on(1, 400, n);
    check("ar interval", n >= 245 && n <= 249, 1'b1);
    stop[1] = 1'b1;
    step(1);
    stop[1] = 1'b0;
    check("ar stopped", running[1], 1'b0);
    check("other kept", running[0], 1'b1);
    wait_on(0, 800, n);
    check("os after stop", irq[0], 1'b1);
  endtask

  task automatic t_width();
    pulse_start(0, 16'hffff, 1'b0);
    check("full count", count[0], 16'hffff);
    n = 0;
    while (count[0] === 16'hffff && n < 130) begin
      step(1);
      n++;
    end
    check("down step", count[0], 16'hfffe);
    pulse_start(0, 16'h0010, 1'b1);
    check("restart count", count[0], 16'h0010);
    check("restart running", running[0], 1'b1);
    stop[0] = 1'b1;
    step(1);
    stop[0] = 1'b0;
    check("wide stop", running[0], 1'b0);
  endtask

  task automatic t_wdog(input logic [2:0] ps, input logic [15:0] ld, input int lo,
                        input int hi);
    wd_ps = ps;
    wd_load = ld;
    wd_en = 1'b1;
    step(1);
    wd_en = 1'b1;
    check("wd load", wd_count, ld);
    wait_on(2, hi + 20, n);
    check("wd timeout", n >= lo && n <= hi, 1'b1);
    step(5);
    check("wd stands", wd_expired, 1'b1);
    wd_en = 1'b0;
    step(2);
    check("wd clear", wd_expired, 1'b0);
  endtask

  task automatic t_kick();
    wd_ps = 3'h0;
    wd_load = 16'h0003;
    wd_en = 1'b1;
    repeat (3) begin
      step(300);
      kick = 1'b1;
      step(1);
      kick = 1'b0;
      check("wd kicked", wd_expired, 1'b0);
    end
    wait_on(2, 500, n);
    check("wd after kick", n >= 320 && n <= 434, 1'b1);
    wd_en = 1'b0;
    step(2);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(2);
    check("rst count", count, 32'h0);
    check("rst flags", {running, irq, wd_expired}, 5'h00);
    rst_n = 1'b1;
    step(4);
    t_one_shot();
    t_auto_and_independence();
    t_width();
    t_wdog(3'h0, 16'h0000, 1, 110);
    t_wdog(3'h2, 16'h0001, 749, 866);
    t_kick();
    conclude();
  end

  initial begin
    step(20000);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
